/* File: hdl/dcm_clock_network.sv */
// Overview of operation
// - eight run-time muxes, two per side
// - enabled mux follows its select bus
// - every mux starts on input 0
// - sixteen local feeds from global, fabric, regional
// - regional feeds: eight top/bottom, four elsewhere
// - region 80 rows, local networks 40 rows
// - local fabric drives its own local network
// - fabric drives each cell clock enable
// - top/bottom interface: 14 global, 2 fabric
// - side interface: four clocks, two fabric
// - glitch-free run-time enable on every global network
// - thirty-two balanced global signals
module dcm_clock_network #(
    parameter int NUM_DYN = dcm_pkg::NUM_DYN,
    parameter int DYN_IN = dcm_pkg::DYN_IN,
    parameter int SEL_W = $clog2(DYN_IN),
    parameter bit TB_REGION = 1'h0
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // dynamic mux sources (pins) and select buses
    input wire logic [NUM_DYN-1:0][DYN_IN-1:0] dyn_src_in,
    input wire logic [NUM_DYN-1:0] dyn_en_in,
    input wire logic [NUM_DYN-1:0][SEL_W-1:0] dyn_sel_in,
    // statically routed global sources (pins) and network enables
    input wire logic [dcm_pkg::NUM_STAT-1:0] stat_src_in,
    input wire logic [dcm_pkg::NUM_GLB-1:0] glb_en_in,
    // regional (pins) and remote fabric signals
    input wire logic [dcm_pkg::RGN_TB-1:0] rgn_in,
    input wire logic [dcm_pkg::NUM_FAB-1:0] fab_remote_in,
    // core local networks
    input wire dcm_pkg::dcm_cand_t
        [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOC_FEEDS-1:0] loc_sel_in,
    input wire logic [dcm_pkg::NUM_LOC-1:0] loc_fab_in,
    input wire logic [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOCAL_ROWS-1:0]
        cell_ce_in,
    // interface local regions
    input wire logic [dcm_pkg::IFC_TB_GLB-1:0][dcm_pkg::GLB_W-1:0]
        ifc_tb_sel_in,
    input wire logic [dcm_pkg::IFC_TB_FAB-1:0] ifc_tb_fab_in,
    input wire dcm_pkg::dcm_cand_t [dcm_pkg::IFC_LR_CLKS-1:0] ifc_lr_sel_in,
    input wire logic [dcm_pkg::IFC_LR_FAB-1:0] ifc_lr_fab_use_in,
    input wire logic [dcm_pkg::IFC_LR_FAB-1:0] ifc_lr_fab_in,
    // distributed clocks
    output logic [dcm_pkg::NUM_GLB-1:0] glb_net_out,
    output logic [NUM_DYN-1:0] dyn_busy_out,
    output logic [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOC_FEEDS-1:0] loc_feed_out,
    output logic [dcm_pkg::NUM_LOC-1:0] loc_fab_out,
    output logic [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOCAL_ROWS-1:0] cell_ce_out,
    output logic [dcm_pkg::IFC_TB_CLKS-1:0] ifc_tb_clk_out,
    output logic [dcm_pkg::IFC_LR_CLKS-1:0] ifc_lr_clk_out
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: stage 1 is read only by stage 2
    logic [NUM_DYN-1:0][DYN_IN-1:0] dyn_s1_q, dyn_s2_q;
    logic [dcm_pkg::NUM_STAT-1:0] stat_s1_q, stat_s2_q;
    logic [dcm_pkg::RGN_TB-1:0] rgn_s1_q, rgn_s2_q;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            dyn_s1_q <= '0;
            dyn_s2_q <= '0;
            stat_s1_q <= '0;
            stat_s2_q <= '0;
            rgn_s1_q <= '0;
            rgn_s2_q <= '0;
        end
        else
        begin
            dyn_s1_q <= dyn_src_in;
            dyn_s2_q <= dyn_s1_q;
            stat_s1_q <= stat_src_in;
            stat_s2_q <= stat_s1_q;
            rgn_s1_q <= rgn_in;
            rgn_s2_q <= rgn_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // dynamic muxes, two per side
    logic [NUM_DYN-1:0] dyn_clk, dyn_busy;

    for (genvar m = 0; m < NUM_DYN; m++)
    begin : g_dyn
        dcm_dyn_mux #(
            .N(DYN_IN),
            .SW(SEL_W)
        ) u_mux (
            .sys_clk_in(sys_clk_in),
            .rst_b_in(rst_b_in),
            .src_in(dyn_s2_q[m]),
            .en_in(dyn_en_in[m]),
            .sel_in(dyn_sel_in[m]),
            .clk_out(dyn_clk[m]),
            .busy_out(dyn_busy[m])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    logic [dcm_pkg::NUM_GLB-1:0] glb_raw, glb_en_q, glb_en_d, glb_q, glb_d;
    logic [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOC_FEEDS-1:0] loc_q, loc_d;
    logic [dcm_pkg::NUM_LOC-1:0] lfab_q, lfab_d;
    logic [dcm_pkg::NUM_LOC-1:0][dcm_pkg::LOCAL_ROWS-1:0] ce_q, ce_d;
    logic [dcm_pkg::IFC_TB_CLKS-1:0] tb_q, tb_d;
    logic [dcm_pkg::IFC_LR_CLKS-1:0] lr_q, lr_d;
    logic [NUM_DYN-1:0] busy_q;
    dcm_pkg::dcm_cand_s cand;

    always_comb
    begin
        glb_raw = {stat_s2_q, dyn_clk};
        // an enable only moves while its clock is low, so no runt pulse
        for (int i = 0; i < dcm_pkg::NUM_GLB; i++)
            glb_en_d[i] = glb_raw[i] ? glb_en_q[i] : glb_en_in[i];
        glb_d = glb_raw & glb_en_q;
        cand.glb = glb_q;
        cand.fab = fab_remote_in;
        cand.rgn = rgn_s2_q;
        // two row halves plus DSP and RAM nets per column
        for (int n = 0; n < dcm_pkg::NUM_LOC; n++)
        begin
            for (int f = 0; f < dcm_pkg::LOC_FEEDS; f++)
                loc_d[n][f] = dcm_pkg::dcm_pick(cand, loc_sel_in[n][f],
                                                TB_REGION);
        end
        lfab_d = loc_fab_in;
        ce_d = cell_ce_in;
        for (int k = 0; k < dcm_pkg::IFC_TB_GLB; k++)
            tb_d[k] = glb_q[ifc_tb_sel_in[k]];
        tb_d[dcm_pkg::IFC_TB_CLKS-1:dcm_pkg::IFC_TB_GLB] = ifc_tb_fab_in;
        for (int k = 0; k < dcm_pkg::IFC_LR_CLKS; k++)
            lr_d[k] = dcm_pkg::dcm_pick(cand, ifc_lr_sel_in[k], TB_REGION);
        // only the low slots may take fabric, capping it at two
        for (int k = 0; k < dcm_pkg::IFC_LR_FAB; k++)
        begin
            if (ifc_lr_fab_use_in[k])
                lr_d[k] = ifc_lr_fab_in[k];
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            glb_en_q <= '0;
            glb_q <= '0;
            loc_q <= '0;
            lfab_q <= '0;
            ce_q <= '0;
            tb_q <= '0;
            lr_q <= '0;
            busy_q <= '0;
        end
        else
        begin
            glb_en_q <= glb_en_d;
            glb_q <= glb_d;
            loc_q <= loc_d;
            lfab_q <= lfab_d;
            ce_q <= ce_d;
            tb_q <= tb_d;
            lr_q <= lr_d;
            busy_q <= dyn_busy;
        end
    end

    assign glb_net_out = glb_q;
    assign dyn_busy_out = busy_q;
    assign loc_feed_out = loc_q;
    assign loc_fab_out = lfab_q;
    assign cell_ce_out = ce_q;
    assign ifc_tb_clk_out = tb_q;
    assign ifc_lr_clk_out = lr_q;

    ////////////////////////////////////////////////////////////////////////
    chk_net_off: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        1'h1 |=> (glb_net_out & ~$past(glb_en_q)) == '0)
        else $error("disabled global network still toggles");

    chk_enable_clean: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        ((glb_en_q ^ $past(glb_en_q)) & $past(glb_raw)) == '0)
        else $error("network enable moved while its clock was high");

    chk_rgn_limit: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (loc_sel_in[0][0] >= dcm_pkg::RGN_BASE + (TB_REGION ?
            dcm_pkg::RGN_TB_LIM : dcm_pkg::RGN_CORE_LIM))
        |=> loc_feed_out[0][0] == 1'h0)
        else $error("regional feed beyond region limit reached network");

    chk_tb_fabric: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        1'h1 |=> ifc_tb_clk_out[dcm_pkg::IFC_TB_CLKS-1:dcm_pkg::IFC_TB_GLB]
            == $past(ifc_tb_fab_in))
        else $error("top/bottom fabric clocks not distributed");

    chk_ce_direct: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        1'h1 |=> cell_ce_out == $past(cell_ce_in))
        else $error("cell clock enable not passed through");

    cov_net_enable: cover property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        glb_en_q == '0 ##1 glb_en_q != '0);

    cov_mux_busy: cover property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        dyn_busy_out != '0 ##[1:20] dyn_busy_out == '0);

    cov_rgn_feed: cover property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        loc_sel_in[0][0] >= dcm_pkg::RGN_BASE ##1 loc_feed_out[0][0]);

endmodule

/* File: hdl/dcm_pkg.sv */
package dcm_pkg;

    // global network: eight run-time muxes, two per device side
    localparam int NUM_SIDES = 4;
    localparam int DYN_PER_SIDE = 2;
    localparam int NUM_DYN = NUM_SIDES * DYN_PER_SIDE;
    localparam int DYN_IN = 4;
    localparam int NUM_GLB = 32;
    localparam int NUM_STAT = NUM_GLB - NUM_DYN;
    localparam int GLB_W = $clog2(NUM_GLB);
    localparam int DEFAULT_SEL = 0;

    // core local networks
    localparam int NUM_FAB = 16;
    localparam int LOC_FEEDS = 16;
    localparam int RGN_TB = 8;
    localparam int RGN_CORE = 4;
    localparam int REGION_ROWS = 80;
    localparam int LOCAL_ROWS = 40;
    localparam int NUM_DSP_RAM_NETS = 2;
    localparam int NUM_LOC = REGION_ROWS / LOCAL_ROWS + NUM_DSP_RAM_NETS;

    // interface local regions
    localparam int IFC_TB_GLB = 14;
    localparam int IFC_TB_FAB = 2;
    localparam int IFC_TB_CLKS = IFC_TB_GLB + IFC_TB_FAB;
    localparam int IFC_LR_CLKS = 4;
    localparam int IFC_LR_FAB = 2;

    // candidate index: globals, then remote fabric, then regional
    localparam int CAND_W = 6;
    typedef logic [CAND_W-1:0] dcm_cand_t;
    localparam dcm_cand_t RGN_BASE = CAND_W'(NUM_GLB + NUM_FAB);
    localparam dcm_cand_t RGN_TB_LIM = CAND_W'(RGN_TB);
    localparam dcm_cand_t RGN_CORE_LIM = CAND_W'(RGN_CORE);

    typedef struct packed {
        logic [RGN_TB-1:0] rgn;
        logic [NUM_FAB-1:0] fab;
        logic [NUM_GLB-1:0] glb;
    } dcm_cand_s;

    typedef enum logic [1:0] {DCM_RUN, DCM_DROP, DCM_PICK} dcm_mux_e;

    // regional candidates beyond the region's limit read as quiet
    function automatic logic dcm_pick(dcm_cand_s c, dcm_cand_t idx,
                                      logic tb);
        dcm_cand_t lim;
        lim = tb ? RGN_TB_LIM : RGN_CORE_LIM;
        if (idx >= RGN_BASE + lim)
            return 1'h0;
        return c[idx];
    endfunction

endpackage

/* File: hdl/dcm_dyn_mux.sv */
module dcm_dyn_mux #(
    parameter int N = dcm_pkg::DYN_IN,
    parameter int SW = $clog2(N)
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // sources and select bus
    input wire logic [N-1:0] src_in,
    input wire logic en_in,
    input wire logic [SW-1:0] sel_in,
    // selected clock
    output logic clk_out,
    output logic busy_out
);

    dcm_pkg::dcm_mux_e st_q, st_d;
    logic [SW-1:0] cur_q, cur_d, tgt_q, tgt_d, want;
    logic on_q, on_d, clk_q, clk_d;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        // disabled mux falls back to input 0
        want = en_in ? sel_in : SW'(dcm_pkg::DEFAULT_SEL);
        st_d = st_q;
        cur_d = cur_q;
        tgt_d = tgt_q;
        on_d = on_q;
        case (st_q)
            dcm_pkg::DCM_RUN:
                if (want != cur_q)
                begin
                    tgt_d = want;
                    st_d = dcm_pkg::DCM_DROP;
                end
            // hangs here if the old clock has stopped high: the user must
            // keep it toggling until it has been seen low
            dcm_pkg::DCM_DROP:
                if (!src_in[cur_q])
                begin
                    on_d = 1'h0;
                    cur_d = tgt_q;
                    st_d = dcm_pkg::DCM_PICK;
                end
            dcm_pkg::DCM_PICK:
                if (!src_in[cur_q])
                begin
                    on_d = 1'h1;
                    st_d = dcm_pkg::DCM_RUN;
                end
            default:
                st_d = dcm_pkg::DCM_RUN;
        endcase
        clk_d = on_q & src_in[cur_q];
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= dcm_pkg::DCM_RUN;
            cur_q <= SW'(dcm_pkg::DEFAULT_SEL);
            tgt_q <= SW'(dcm_pkg::DEFAULT_SEL);
            on_q <= 1'h1;
            clk_q <= 1'h0;
        end
        else
        begin
            st_q <= st_d;
            cur_q <= cur_d;
            tgt_q <= tgt_d;
            on_q <= on_d;
            clk_q <= clk_d;
        end
    end

    assign clk_out = clk_q;
    assign busy_out = (st_q != dcm_pkg::DCM_RUN);

    ////////////////////////////////////////////////////////////////////////
    chk_pick_quiet: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        st_q == dcm_pkg::DCM_PICK |=> clk_out == 1'h0)
        else $error("mux output active while new clock is gated");

    chk_drop_order: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (st_q == dcm_pkg::DCM_DROP && !src_in[cur_q])
        |=> st_q == dcm_pkg::DCM_PICK && !on_q && cur_q == $past(tgt_q))
        else $error("old clock not gated off before new one");

    chk_sel_follow: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (st_q == dcm_pkg::DCM_RUN && en_in && sel_in != cur_q)
        |=> st_q == dcm_pkg::DCM_DROP && tgt_q == $past(sel_in))
        else $error("select bus change not taken");

    chk_default_zero: assert property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        (st_q == dcm_pkg::DCM_RUN && !en_in && cur_q != '0)
        |=> tgt_q == '0)
        else $error("disabled mux does not return to input 0");

    cov_switch_done: cover property (
        @(posedge sys_clk_in) disable iff (!rst_b_in)
        st_q == dcm_pkg::DCM_PICK ##1 st_q == dcm_pkg::DCM_RUN);

endmodule

/* File: tb/dcm_src_model.sv */
module dcm_src_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    // source clocks, input i toggles every i+2 cycles
    output logic [dcm_pkg::NUM_DYN-1:0][dcm_pkg::DYN_IN-1:0] src_out
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [3:0] cnt_q [dcm_pkg::DYN_IN];

    // every input keeps running, so a switch is never left hanging
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            src_out <= '0;
            for (int i = 0; i < dcm_pkg::DYN_IN; i++)
                cnt_q[i] <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < dcm_pkg::DYN_IN; i++)
            begin
                cnt_q[i] <= (cnt_q[i] == 4'(i + 1)) ? 4'h0 : cnt_q[i] + 4'h1;
                if (cnt_q[i] == 4'(i + 1))
                begin
                    for (int m = 0; m < dcm_pkg::NUM_DYN; m++)
                        src_out[m][i] <= ~src_out[m][i];
                end
            end
        end
    end
endmodule

/* File: tb/dynamic_clock_mux_network_test.sv */
module dynamic_clock_mux_network_test;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [23:0] STAT_PAT = 24'hA5C3F0;
    localparam logic [7:0] RGN_PAT = 8'hB6;
    localparam logic [15:0] FAB_PAT = 16'h5A3C;
    localparam logic [39:0] CE_PAT = 40'h5AC3F00F96;

    logic sys_clk_in;
    logic rst_b_in;
    logic [7:0][3:0] dyn_src;
    logic [7:0] dyn_en;
    logic [7:0][1:0] dyn_sel;
    logic [23:0] stat_src;
    logic [31:0] glb_en;
    logic [7:0] rgn;
    logic [15:0] fab_rem;
    dcm_pkg::dcm_cand_t [3:0][15:0] loc_sel;
    logic [3:0] loc_fab;
    logic [3:0][39:0] cell_ce;
    logic [13:0][4:0] tb_sel;
    logic [1:0] tb_fab;
    dcm_pkg::dcm_cand_t [3:0] lr_sel;
    logic [1:0] lr_use;
    logic [1:0] lr_fab;
    logic [31:0] glb_net;
    logic [7:0] busy;
    logic [3:0][15:0] loc_feed;
    logic [3:0][15:0] loc_feed_e;
    logic [3:0] loc_fab_o;
    logic [3:0][39:0] cell_ce_o;
    logic [15:0] tb_clk;
    logic [3:0] lr_clk;
    int errors;
    int checks;

    dcm_src_model i_src (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .src_out(dyn_src));

    dcm_clock_network i_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .dyn_src_in(dyn_src), .dyn_en_in(dyn_en), .dyn_sel_in(dyn_sel),
        .stat_src_in(stat_src), .glb_en_in(glb_en), .rgn_in(rgn),
        .fab_remote_in(fab_rem), .loc_sel_in(loc_sel), .loc_fab_in(loc_fab),
        .cell_ce_in(cell_ce), .ifc_tb_sel_in(tb_sel), .ifc_tb_fab_in(tb_fab),
        .ifc_lr_sel_in(lr_sel), .ifc_lr_fab_use_in(lr_use),
        .ifc_lr_fab_in(lr_fab), .glb_net_out(glb_net), .dyn_busy_out(busy),
        .loc_feed_out(loc_feed), .loc_fab_out(loc_fab_o),
        .cell_ce_out(cell_ce_o), .ifc_tb_clk_out(tb_clk),
        .ifc_lr_clk_out(lr_clk));

    // an edge region admits eight regional candidates, not four
    dcm_clock_network #(
        .TB_REGION(1'h1)
    ) i_dut_edge (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
        .dyn_src_in(dyn_src), .dyn_en_in(dyn_en), .dyn_sel_in(dyn_sel),
        .stat_src_in(stat_src), .glb_en_in(glb_en), .rgn_in(rgn),
        .fab_remote_in(fab_rem), .loc_sel_in(loc_sel), .loc_fab_in(loc_fab),
        .cell_ce_in(cell_ce), .ifc_tb_sel_in(tb_sel), .ifc_tb_fab_in(tb_fab),
        .ifc_lr_sel_in(lr_sel), .ifc_lr_fab_use_in(lr_use),
        .ifc_lr_fab_in(lr_fab), .glb_net_out(), .dyn_busy_out(),
        .loc_feed_out(loc_feed_e), .loc_fab_out(), .cell_ce_out(),
        .ifc_tb_clk_out(), .ifc_lr_clk_out());

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        sys_clk_in = 1'h0;
        forever #20 sys_clk_in = ~sys_clk_in;
    end

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string what, input logic [63:0] exp,
                       input logic [63:0] got);
        checks++;
        if (got !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // inputs change 1 ns after the edge, outputs are settled by then
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
        #1;
    endtask

    task automatic wait_busy(input logic [7:0] mask);
        logic [7:0] seen;
        int t;
        seen = 8'h00;
        t = 0;
        while (t < 80 && (seen !== mask || (busy & mask) !== 8'h00))
        begin
            step(1);
            seen = seen | (busy & mask);
            t++;
        end
        chk("busy_seen", mask, seen);
        chk("busy_end", 8'h00, busy & mask);
    endtask

    // rising edges in 120 cycles tell which source a global net carries
    task automatic rate_all();
        int n [8];
        int e;
        logic [7:0] prev;
        step(8);
        prev = glb_net[7:0];
        for (int m = 0; m < 8; m++)
            n[m] = 0;
        repeat (120)
        begin
            step(1);
            for (int m = 0; m < 8; m++)
                n[m] += (glb_net[m] === 1'h1 && prev[m] === 1'h0) ? 1 : 0;
            prev = glb_net[7:0];
        end
        for (int m = 0; m < 8; m++)
        begin
            e = 120 / (2 * ((dyn_en[m] ? int'(dyn_sel[m]) : 0) + 2));
            chk("dyn_rate", e, (n[m] >= e - 1 && n[m] <= e + 1) ? e : n[m]);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic t_switch();
        for (int m = 0; m < 8; m++)
            dyn_sel[m] = 2'(m % 3 + 1);
        dyn_en = 8'hFF;
        wait_busy(8'hFF);
        rate_all();
    endtask

    // a new select during a switch waits, then is taken
    task automatic t_refuse();
        int t;
        dyn_sel[0] = 2'h3;
        t = 0;
        while (t < 20 && busy[0] !== 1'h1)
        begin
            step(1);
            t++;
        end
        chk("busy_rise", 1'h1, busy[0]);
        dyn_sel[0] = 2'h2;
        t = 0;
        while (t < 80 && busy[0] !== 1'h0)
        begin
            step(1);
            t++;
        end
        wait_busy(8'h01);
        rate_all();
    endtask

    task automatic t_disable();
        dyn_en = 8'h00;
        wait_busy(8'hFF);
        rate_all();
    endtask

    task automatic t_static();
        stat_src = STAT_PAT;
        step(6);
        chk("glb_static", STAT_PAT, glb_net[31:8]);
        glb_en[31:8] = 24'h000000;
        step(4);
        stat_src = 24'hFFFFFF;
        step(6);
        chk("glb_gate_hold", STAT_PAT, glb_net[31:8]);
        stat_src = 24'h000000;
        step(4);
        stat_src = 24'hFFFFFF;
        step(6);
        chk("glb_gate_off", 24'h000000, glb_net[31:8]);
        stat_src = 24'h000000;
        step(4);
        glb_en[31:8] = 24'hFFFFFF;
        step(4);
        stat_src = STAT_PAT;
        step(6);
        chk("glb_gate_on", STAT_PAT, glb_net[31:8]);
    endtask

    task automatic t_local();
        logic [3:0][15:0] exp;
        rgn = RGN_PAT;
        fab_rem = FAB_PAT;
        loc_fab = 4'hA;
        cell_ce = {4{CE_PAT}};
        for (int f = 0; f < 16; f++)
        begin
            loc_sel[0][f] = 6'(8 + f);
            loc_sel[1][f] = 6'(32 + f);
            loc_sel[2][f] = 6'(48 + f % 8);
            loc_sel[3][f] = 6'(48 + f % 4);
            exp[0][f] = STAT_PAT[f];
            exp[1][f] = FAB_PAT[f];
            exp[2][f] = (f % 8 < 4) ? RGN_PAT[f % 8] : 1'h0;
            exp[3][f] = RGN_PAT[f % 4];
        end
        step(6);
        for (int n = 0; n < 4; n++)
        begin
            chk("loc_feed", exp[n], loc_feed[n]);
            chk("cell_ce", CE_PAT, cell_ce_o[n]);
        end
        chk("loc_feed_edge", {2{RGN_PAT}}, loc_feed_e[2]);
        chk("loc_fab", 4'hA, loc_fab_o);
        loc_sel[0][0] = 6'h31;
        step(2);
        chk("loc_rgn_in", RGN_PAT[1], loc_feed[0][0]);
        loc_sel[0][0] = 6'h34;
        step(2);
        chk("loc_rgn_cut", 1'h0, loc_feed[0][0]);
        chk("loc_edge_rgn", RGN_PAT[4], loc_feed_e[0][0]);
    endtask

    task automatic t_ifc();
        for (int j = 0; j < 14; j++)
            tb_sel[j] = 5'(8 + j);
        tb_fab = 2'h2;
        lr_sel = {6'h36, 6'h32, 6'h23, 6'h09};
        lr_use = 2'h1;
        lr_fab = 2'h1;
        step(6);
        chk("ifc_tb", {2'h2, STAT_PAT[13:0]}, tb_clk);
        chk("ifc_lr", {1'h0, RGN_PAT[2], FAB_PAT[3], 1'h1}, lr_clk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        checks = 0;
        rst_b_in = 1'h0;
        {dyn_en, dyn_sel, stat_src, rgn, fab_rem, loc_fab} = '0;
        {loc_sel, cell_ce, tb_sel, tb_fab, lr_sel, lr_use, lr_fab} = '0;
        glb_en = 32'hFFFFFFFF;
        step(4);
        rst_b_in = 1'h1;
        step(2);
        chk("busy_reset", 8'h00, busy);
        rate_all();
        t_switch();
        t_refuse();
        t_disable();
        t_static();
        t_local();
        t_ifc();
        results();
    end

    initial
    begin
        #400000;
        errors++;
        results();
    end
endmodule
